// File: bench/ops_status_sva.sv
// Port checker for ops_status.
// Assumes one start in flight at a time and no reset in mid-run.
module ops_status_sva
  import ops_pkg::*;
#(
  parameter int unsigned BURN_CYCLES = 20
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        UNLOCK_SET,
  input wire logic        LOAD_PAGE1,
  input wire logic        LOAD_DED,
  input wire logic        BURN_EN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic       unl_r;
  logic [9:0] go_r;
  logic [9:0] bn_r;
  wire        rd1 = REG_RD && REG_ADDR == ADDR_PAGE1_STAT;
  wire        go  = REG_WR && REG_ADDR == ADDR_PROG_CTRL && REG_WDATA[0];
  // Mirror of the unlock state, so a locked start never restarts the count
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      unl_r <= 1'h0;
      go_r  <= 10'h3ff;
      bn_r  <= 10'h000;
    end else begin
      unl_r <= UNLOCK_SET | (unl_r & ~REG_WR);
      go_r  <= (go && unl_r && !BURN_EN) ? 10'h000 : go_r + {9'h000, go_r != 10'h3ff};
      bn_r  <= BURN_EN ? bn_r + 10'h001 : 10'h000;
    end
  end
  sequence s_load;
    LOAD_PAGE1 ##1 rd1;
  endsequence
  property p_rst;
    $rose(RST_N) |-> !BURN_EN && REG_RDATA == STAT_RESET;
  endproperty
  property p_hold;
    !REG_RD |=> $stable(REG_RDATA);
  endproperty
  property p_unmapped;
    REG_RD && REG_ADDR[15:8] != 8'h05 |=> REG_RDATA == 8'h00;
  endproperty
  property p_fmt;
    rd1 |=> REG_RDATA[P1_FMT] == ((REG_RDATA[P1_NO_LOW_SUPPLY_SEEN] | REG_RDATA[P1_NO_HIGH_SUPPLY_SEEN]) & ~REG_RDATA[P1_TRY]);
  endproperty
  property p_valid;
    rd1 |=> !REG_RDATA[P1_VALID] || (REG_RDATA[P1_TRY] && REG_RDATA[P1_NO_LOW_SUPPLY_SEEN] && REG_RDATA[P1_NO_HIGH_SUPPLY_SEEN]);
  endproperty
  property p_load;
    s_load |=> REG_RDATA[P1_LOADED] && REG_RDATA[P1_LDERR] == $past(LOAD_DED, 2);
  endproperty
  property p_burn_start;
    $rose(BURN_EN) |-> go_r >= STAB_CYCLES && go_r <= STAB_CYCLES + 3;
  endproperty
  property p_burn_len;
    $fell(BURN_EN) |-> bn_r == BURN_CYCLES;
  endproperty
  a_rst:        assert property (p_rst) else $error("outputs not clear after reset");
  a_hold:       assert property (p_hold) else $error("read data moved without read");
  a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
  a_fmt:        assert property (p_fmt) else $error("format fault mismatch");
  a_valid:      assert property (p_valid) else $error("valid without clean try");
  a_load:       assert property (p_load) else $error("load status wrong");
  a_burn_start: assert property (p_burn_start) else $error("burn without unlocked start");
  a_burn_len:   assert property (p_burn_len) else $error("burn length wrong");
endmodule : ops_status_sva

bind ops_status ops_status_sva #(.BURN_CYCLES(BURN_CYCLES)) u_sva (.CLK(CLK), .RST_N(RST_N),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .UNLOCK_SET(UNLOCK_SET), .LOAD_PAGE1(LOAD_PAGE1),
  .LOAD_DED(LOAD_DED), .BURN_EN(BURN_EN));

// File: bench/testbench.sv
// Self-checking bench for ops_status through its native register port.
// Assumes a short burn count; supply levels are set just before a start, except in the last run, which raises VPP_HIGH during the burn.
module testbench
  import ops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
  logic CLK = 1'h0, RST_N = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0;
  logic UNLOCK_SET = 1'h0, VPP_LOW = 1'h0, VPP_HIGH = 1'h0;
  logic LOAD_PAGE1 = 1'h0, LOAD_DED = 1'h0, LOAD_SEC = 1'h0, BURN_EN, BURN_PAGE2;
  logic [15:0] REG_ADDR = 16'h0000;
  logic [7:0]  REG_WDATA = 8'h00, REG_RDATA;
  int err_total = 0, num_checks = 0, cyc = 0;
  always #2 CLK = ~CLK;
  ops_status #(.BURN_CYCLES(20)) u_dut (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .UNLOCK_SET(UNLOCK_SET), .VPP_LOW(VPP_LOW), .VPP_HIGH(VPP_HIGH), .LOAD_PAGE1(LOAD_PAGE1),
    .LOAD_DED(LOAD_DED), .LOAD_SEC(LOAD_SEC), .BURN_EN(BURN_EN), .BURN_PAGE2(BURN_PAGE2));
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // UNLOCK_SET and LOAD_PAGE1 pulses set by the caller are dropped on the first edge of any access
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK) {REG_WR, REG_ADDR, REG_WDATA, UNLOCK_SET, LOAD_PAGE1} <= {1'h1, a, d, 2'h0};
    @(posedge CLK) REG_WR <= 1'h0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge CLK) {REG_RD, REG_ADDR, UNLOCK_SET, LOAD_PAGE1} <= {1'h1, a, 2'h0};
    @(posedge CLK) REG_RD <= 1'h0;
    @(posedge CLK);
    `CHK(REG_RDATA & m, e)
  endtask : rd
  task go(input logic pg, input int n);
    wr(ADDR_PROG_CTRL, {6'h00, pg, 1'h1});
    repeat (n) @(posedge CLK);
  endtask : go
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'h1;
    rd(ADDR_PAGE1_STAT, 8'h00);
    wr(ADDR_PAGE1_STAT, 8'hff);
    wr(ADDR_PROG_STAT, 8'hff);
    rd(ADDR_PAGE1_STAT, 8'h00);
    rd(ADDR_PROG_STAT, 8'h00);
    rd(16'h0000, 8'h00);
    go(1'h0, 30);
    rd(ADDR_PROG_STAT, 8'h02);
    {LOAD_PAGE1, LOAD_DED, LOAD_SEC} <= 3'h7;
    rd(ADDR_PAGE1_STAT, 8'he0);
    UNLOCK_SET <= 1'h1;
    rd(ADDR_PROG_STAT, 8'h82);
    wr(16'h0000, 8'h00);
    rd(ADDR_PROG_STAT, 8'h02);
    {VPP_HIGH, UNLOCK_SET} <= 2'h3;
    go(1'h0, 530);
    rd(ADDR_PROG_STAT, 8'h04);
    rd(ADDR_PAGE1_STAT, 8'he0);
    {VPP_HIGH, VPP_LOW, UNLOCK_SET} <= 3'h3;
    go(1'h0, 530);
    rd(ADDR_PROG_STAT, 8'h08);
    {VPP_LOW, UNLOCK_SET} <= 2'h1;
    go(1'h0, 560);
    rd(ADDR_PROG_STAT, 8'h01);
    rd(ADDR_PAGE1_STAT, 8'hef);
    UNLOCK_SET <= 1'h1;
    go(1'h0, 30);
    rd(ADDR_PROG_STAT, 8'h02);
    UNLOCK_SET <= 1'h1;
    go(1'h1, 510);
    VPP_HIGH <= 1'h1;
    `CHK(BURN_PAGE2, 1'h1)
    repeat (40) @(posedge CLK);
    rd(ADDR_PROG_STAT, 8'h31, 8'h31);
    complete_run();
  end
endmodule : testbench

// File: common/ops_pkg.sv
// Constants for the one-time-programmable page status block.
// Assumes a single 250 MHz core clock and an 8-bit native register port.
//
// Contract
// [RULE_01] A stability test of the programming supply runs before burning and flags undervoltage.
// [RULE_02] The same test flags overvoltage; a start command clears that flag.
// [RULE_03] A start while locked, or on a page already tried or badly formatted, is an error; the code checks tried and format for page 1 only.
// [RULE_04] The completion flag rises when burning of the page ends and clears on start.
// [RULE_05] The page-1 loaded bit is 1 once page 1 has been chosen and copied out.
// [RULE_06] The page-1 load fault bit is 1 when a double error is found during that load.
// [RULE_07] The page-1 format fault is any supply-ok bit set while the first-attempt bit is 0.
// [RULE_08] The page-1 valid bit is 1 only after a burn of page 1 that saw no supply fault.
// [RULE_09] The page-1 low-supply-ok bit is 1 only after an attempt that saw no undervoltage.
// [RULE_10] The page-1 high-supply-ok bit is 1 only after an attempt that saw no overvoltage.
// [RULE_11] An overvoltage also counts as an undervoltage, so both ok bits may read 0.
// [RULE_12] The page-1 first-attempt bit goes to 1 on the first burn attempt and stays.
// [RULE_13] Unlock clears on any register write except the control write, and on start.
// [RULE_14] Software writes to both status registers are ignored; all bits reset to 0.
package ops_pkg;

  localparam int unsigned CLK_PERIOD_NS = 4;

  // Register addresses
  localparam logic [15:0] ADDR_PROG_STAT  = 16'h0519;
  localparam logic [15:0] ADDR_PAGE1_STAT = 16'h051a;
  localparam logic [15:0] ADDR_PROG_CTRL  = 16'h0516;

  // Control write fields
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_PAGE_BIT = 1;

  // Programming status fields
  localparam int unsigned PS_UNLOCK = 7;
  localparam int unsigned PS_OTERR  = 6;
  localparam int unsigned PS_UVERR  = 5;
  localparam int unsigned PS_OVERR  = 4;
  localparam int unsigned PS_SLOW   = 3;
  localparam int unsigned PS_SHIGH  = 2;
  localparam int unsigned PS_PERR   = 1;
  localparam int unsigned PS_DONE   = 0;

  // Page 1 status fields
  localparam int unsigned P1_LOADED = 7;
  localparam int unsigned P1_LDWRN  = 6;
  localparam int unsigned P1_LDERR  = 5;
  localparam int unsigned P1_FMT    = 4;
  localparam int unsigned P1_VALID  = 3;
  localparam int unsigned P1_NO_LOW_SUPPLY_SEEN   = 2;
  localparam int unsigned P1_NO_HIGH_SUPPLY_SEEN   = 1;
  localparam int unsigned P1_TRY    = 0;

  localparam logic [7:0] STAT_RESET = 8'h00;

  // Timing
  localparam int unsigned STAB_TIME_NS   = 2000;
  localparam int unsigned STAB_CYCLES    = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BURN_TIME_NS   = 100000;
  localparam int unsigned BURN_CYCLES_DF = BURN_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OPS_IDLE = 2'b00,
    OPS_STAB = 2'b01,
    OPS_BURN = 2'b10
  } ops_state_t;

endpackage : ops_pkg

// File: src/ops_status.sv
// Programming sequencer status and page-1 status registers.
// Assumes an 8-bit register port on CLK, an unlock pulse from the unlock
// logic and asynchronous supply comparators on pins.
module ops_status
  import ops_pkg::*;
#(
  parameter int unsigned BURN_CYCLES = BURN_CYCLES_DF
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        UNLOCK_SET,
  input  wire logic        VPP_LOW,
  input  wire logic        VPP_HIGH,
  input  wire logic        LOAD_PAGE1,
  input  wire logic        LOAD_DED,
  input  wire logic        LOAD_SEC,
  output logic             BURN_EN,
  output logic             BURN_PAGE2
);

  localparam int unsigned CW = $clog2(BURN_CYCLES + STAB_CYCLES + 1);
  localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES - 1);
  localparam logic [CW-1:0] BURN_LAST = CW'(BURN_CYCLES - 1);

  ops_state_t    state_r;
  ops_state_t    state_nxt;
  logic [CW-1:0] cnt_r;
  logic [1:0]    vpp_s;
  logic          unlock_r;
  logic          uverr_r;
  logic          overr_r;
  logic          slow_r;
  logic          shigh_r;
  logic          perr_r;
  logic          done_r;
  logic          page2_r;
  logic          loaded_r;
  logic          ldwrn_r;
  logic          lderr_r;
  logic          valid_r;
  logic          no_low_supply_seen_r;
  logic          no_high_supply_seen_r;
  logic          try_r;
  logic          uv_seen_r;
  logic          ov_seen_r;

  ops_sync #(.WIDTH(2)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({VPP_HIGH, VPP_LOW}),
    .q     (vpp_s)
  );

  wire vlow      = vpp_s[0];
  wire vhigh     = vpp_s[1];
  wire ctrl_wr   = REG_WR && (REG_ADDR == ADDR_PROG_CTRL);
  wire go        = ctrl_wr && REG_WDATA[CTRL_GO_BIT];
  wire go_page2  = REG_WDATA[CTRL_PAGE_BIT];
  wire fmt_fault = (no_low_supply_seen_r || no_high_supply_seen_r) && !try_r;                       // [RULE_07]
  // Page 2 bookkeeping lives elsewhere; only page 1 is checked here
  wire bad_page  = !go_page2 && (try_r || fmt_fault);
  wire go_err    = go && (state_r == OPS_IDLE) && (!unlock_r || bad_page); // [RULE_03]
  wire go_ok     = go && (state_r == OPS_IDLE) && !go_err;
  wire stab_end  = (state_r == OPS_STAB) && (cnt_r == STAB_LAST);
  wire stab_bad  = stab_end && (uv_seen_r || ov_seen_r);
  wire burn_end  = (state_r == OPS_BURN) && (cnt_r == BURN_LAST);
  wire p1_burn   = burn_end && !page2_r;
  // Overvoltage shuts the pump down, which also shows as undervoltage
  wire uv_any    = uv_seen_r || vlow || ov_seen_r || vhigh;            // [RULE_11]
  wire ov_any    = ov_seen_r || vhigh;

  wire [7:0] prog_stat = {unlock_r, 1'b0, uverr_r, overr_r, slow_r, shigh_r, perr_r, done_r};
  wire [7:0] page1_stat = {loaded_r, ldwrn_r, lderr_r, fmt_fault,
                           valid_r, no_low_supply_seen_r, no_high_supply_seen_r, try_r};
  wire [7:0] rd_mux = (REG_ADDR == ADDR_PROG_STAT)  ? prog_stat  :
                      (REG_ADDR == ADDR_PAGE1_STAT) ? page1_stat : STAT_RESET;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      OPS_IDLE: if (go_ok) begin
        state_nxt = OPS_STAB;                                          // [RULE_01]
      end
      OPS_STAB: if (stab_end) begin
        state_nxt = stab_bad ? OPS_IDLE : OPS_BURN;
      end
      OPS_BURN: if (burn_end) begin
        state_nxt = OPS_IDLE;
      end
      default: state_nxt = OPS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= OPS_IDLE;
      cnt_r   <= '0;
      page2_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + CW'(1);
      if (go_ok) begin
        page2_r <= go_page2;
      end
    end
  end

  // Supply faults seen in the current phase; cleared at each phase start
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      uv_seen_r <= 1'b0;
      ov_seen_r <= 1'b0;
    end else if (state_nxt != state_r) begin
      uv_seen_r <= 1'b0;
      ov_seen_r <= 1'b0;
    end else if (state_r != OPS_IDLE) begin
      uv_seen_r <= uv_seen_r || vlow;
      ov_seen_r <= ov_seen_r || vhigh;
    end
  end

  // Unlock: a new unlock pulse wins over a clearing write in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      unlock_r <= 1'b0;
    end else if (UNLOCK_SET) begin
      unlock_r <= 1'b1;
    end else if ((REG_WR && !ctrl_wr) || go) begin
      unlock_r <= 1'b0;                                                // [RULE_13]
    end
  end

  // Sequencer flags: start clears them and loads perr_r with go_err, outcomes set them
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slow_r  <= 1'b0;
      shigh_r <= 1'b0;
      perr_r  <= 1'b0;
      done_r  <= 1'b0;
      uverr_r <= 1'b0;
      overr_r <= 1'b0;
    end else if (go && state_r == OPS_IDLE) begin
      slow_r  <= 1'b0;                                                 // [RULE_01]
      shigh_r <= 1'b0;                                                 // [RULE_02]
      perr_r  <= go_err;                                               // [RULE_03]
      done_r  <= 1'b0;                                                 // [RULE_04]
      uverr_r <= 1'b0;
      overr_r <= 1'b0;
    end else begin
      if (stab_end) begin
        slow_r  <= uv_seen_r || vlow;                                  // [RULE_01]
        shigh_r <= ov_seen_r || vhigh;                                 // [RULE_02]
      end
      if (burn_end) begin
        done_r  <= 1'b1;                                               // [RULE_04]
        uverr_r <= uv_any;
        overr_r <= ov_any;
      end
    end
  end

  // Page 1 burn record; writes never reach these bits
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      try_r   <= 1'b0;
      no_low_supply_seen_r  <= 1'b0;
      no_high_supply_seen_r  <= 1'b0;
      valid_r <= 1'b0;                                                 // [RULE_14]
    end else begin
      if (stab_end && !stab_bad && !page2_r) begin
        try_r <= 1'b1;                                                 // [RULE_12]
      end
      if (p1_burn) begin
        no_low_supply_seen_r  <= !uv_any;                                            // [RULE_09] [RULE_11]
        no_high_supply_seen_r  <= !ov_any;                                            // [RULE_10]
        valid_r <= !uv_any && !ov_any;                                 // [RULE_08]
      end
    end
  end

  // Page 1 load result, reported by the loader
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      loaded_r <= 1'b0;
      lderr_r  <= 1'b0;
      ldwrn_r  <= 1'b0;
    end else if (LOAD_PAGE1) begin
      loaded_r <= 1'b1;                                                // [RULE_05]
      lderr_r  <= LOAD_DED;                                            // [RULE_06]
      ldwrn_r  <= LOAD_SEC;
    end
  end

  // Read data is registered; unmapped reads return zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA  <= STAT_RESET;
      BURN_EN    <= 1'b0;
      BURN_PAGE2 <= 1'b0;
    end else begin
      if (REG_RD) begin
        REG_RDATA <= rd_mux;                                           // [RULE_14]
      end
      BURN_EN    <= (state_nxt == OPS_BURN);
      BURN_PAGE2 <= page2_r;
    end
  end

endmodule : ops_status

// File: src/ops_sync.sv
// Two-stage synchroniser for asynchronous comparator levels.
// Assumes the inputs are quasi-static levels.
module ops_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : ops_sync
